// File: logic/bts_sequencer.sv
`include "bts_params.svh"
`default_nettype none
module bts_sequencer #(
	parameter int AW = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// monitored core bus pins
	input wire logic mon_valid,
	input wire logic mon_fetch,
	input wire logic [1:0] mon_cyc,
	input wire logic [3:0] mon_ext,
	input wire logic [15:0] mon_addr,
	input wire logic [15:0] mon_data,
	// events
	output logic irq,
	output logic halt_req
);
	// ---------------------------------------------
	// state
	// ---------------------------------------------
	typedef struct packed {
		bts_pkg::bts_bus_t s1;
		bts_pkg::bts_bus_t s2;
		bts_pkg::bts_cfg_t cfg;
		logic [3:0][4:0] opt;
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [15:0] cmp_d;
		logic [3:0][1:0] jtgt;
		logic [3:0] irq_st;
		logic [3:0] irq_mask;
		bts_pkg::bts_run_t run;
		logic [1:0] seq;
		logic [31:0] tnow;
		logic [31:0] tlast;
		logic [31:0] rtime;
		logic [31:0] ptime;
		logic rt_on;
		logic pt_on;
		logic [AW-1:0] wptr;
		logic [AW:0] cnt;
		logic wrapped;
		logic [AW-1:0] mark_idx;
		logic [31:0] mark_time;
		logic [1:0] mark_ld;
		logic [AW-1:0] rd_idx;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic irq;
		logic halt;
	} bts_state_t;

	localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

	bts_state_t st;
	bts_state_t n;
	bts_pkg::bts_bus_t b;
	bts_pkg::bts_res_t res;
	bts_pkg::bts_smp_t smp_w;
	bts_pkg::bts_smp_t dout;
	logic [AW-1:0] mem_raddr;
	logic qual;
	logic hit_a;
	logic hit_b;
	logic in_rng;
	logic dmatch;
	logic ev;
	logic bp_hit;
	logic trc;
	logic rt_ev;
	logic pt_ev;
	logic last;
	logic [1:0] jt;
	logic [1:0] nxt_raw;
	logic [1:0] nxt;
	logic acc;
	logic wr;
	logic mk_ok;
	logic [31:0] ts_view;

	// ---------------------------------------------
	// option decode of the active state
	// ---------------------------------------------
	bts_option_decode u_dec (
		.code(st.opt[st.seq]),
		.res(res)
	);

	// ---------------------------------------------
	// trace buffer
	// ---------------------------------------------
	bts_trace_mem #(.W($bits(bts_pkg::bts_smp_t)), .AW(AW)) u_mem (
		.pclk(pclk),
		.we(trc),
		.waddr(st.wptr),
		.wdata(smp_w),
		.raddr(mem_raddr),
		.rdata(dout)
	);

	// ---------------------------------------------
	// event qualification
	// ---------------------------------------------
	assign b = st.s2;
	assign qual = (!st.cfg.instruction_fetch_trace_en || b.fetch)
		&& (!st.cfg.ext_en || ((b.ext ^ st.cfg.ext_val) & st.cfg.ext_mask) == 4'h0);
	assign hit_a = b.addr == st.cmp_a;
	assign hit_b = b.addr == st.cmp_b;
	assign in_rng = (b.addr >= st.cmp_a) && (b.addr <= st.cmp_b);
	assign dmatch = res.addr_only || (b.data == st.cmp_d);
	assign ev = (st.run == bts_pkg::BTS_RUN) && b.valid && qual;
	assign bp_hit = ev && (res.bp != 3'd0) && (hit_a || (res.bp > 3'd1 && hit_b)) && dmatch;
	assign trc = ev && (res.tr != 3'd0) && in_rng && dmatch;
	always_comb begin
		case (st.cfg.rmode)
			`BTS_RM_ONE: rt_ev = hit_a;
			`BTS_RM_EITHER: rt_ev = hit_a || hit_b;
			`BTS_RM_IN: rt_ev = in_rng;
			default: rt_ev = !in_rng;
		endcase
		rt_ev = rt_ev && ev && (res.rt != 2'd0);
	end
	assign pt_ev = ev && (res.pt != 2'd0) && (hit_a || (res.pt > 2'd1 && hit_b));

	// ---------------------------------------------
	// next state of the sequence
	// ---------------------------------------------
	// state three ends
	assign last = (st.seq == st.cfg.eos) || (st.seq == 2'd3);
	assign jt = st.jtgt[st.seq];
	assign nxt_raw = (res.jmp != 2'd0) ? jt : st.seq + 2'd1;
	assign nxt = (nxt_raw > st.cfg.eos) ? st.cfg.eos : nxt_raw;

	// ---------------------------------------------
	// sample and views
	// ---------------------------------------------
	// sample fields
	assign smp_w = {st.tnow, st.tnow - st.tlast, b.cyc, b.ext, b.addr, b.data};
	assign mem_raddr = (st.mark_ld == 2'd1) ? st.mark_idx : st.rd_idx;
	always_comb begin
		case (st.cfg.view)
			`BTS_VIEW_DELTA: ts_view = dout.delta;
			`BTS_VIEW_MARK: ts_view = dout.tstamp - st.mark_time;
			default: ts_view = dout.tstamp;
		endcase
	end

	// ---------------------------------------------
	// bus handshake
	// ---------------------------------------------
	assign acc = psel && penable && !st.pready && (st.mark_ld == 2'd0);
	assign wr = psel && penable && st.pready && pwrite;
	assign mk_ok = st.wrapped || ({1'b0, pwdata[AW-1:0]} < st.cnt);

	// ---------------------------------------------
	// next value
	// ---------------------------------------------
	always_comb begin
		logic [3:0] set;
		logic [3:0] clr;
		set = 4'h0;
		clr = 4'h0;
		n = st;
		n.s1 = {mon_valid, mon_fetch, mon_cyc, mon_ext, mon_addr, mon_data};
		n.s2 = st.s1;
		// free-running time while in run mode
		if (st.run == bts_pkg::BTS_RUN) begin
			n.tnow = st.tnow + 32'd1;
			if (st.rt_on) begin
				n.rtime = st.rtime + 32'd1;
			end
			if (st.pt_on) begin
				n.ptime = st.ptime + 32'd1;
			end
		end
		// timer toggles, kept across state changes
		if (rt_ev) begin
			n.rt_on = !st.rt_on;
			set[`BTS_IRQ_TMR] = 1'b1;
		end
		if (pt_ev) begin
			n.pt_on = !st.pt_on;
			set[`BTS_IRQ_TMR] = 1'b1;
		end
		// breakpoint advances or ends the sequence
		if (bp_hit) begin
			if (last) begin
				n.run = bts_pkg::BTS_HALT;
				set[`BTS_IRQ_BP] = 1'b1;
			end else begin
				n.seq = nxt;
			end
		end
		if (trc) begin
			n.tlast = st.tnow;
			n.wptr = st.wptr + 1'b1;
			set[`BTS_IRQ_TRC] = 1'b1;
			if (st.cnt != DEPTH) begin
				n.cnt = st.cnt + 1'b1;
			end
			if (st.wptr == {AW{1'b1}}) begin
				n.wrapped = 1'b1;
				set[`BTS_IRQ_WRAP] = 1'b1;
			end
		end
		case (st.mark_ld)
			2'd1: n.mark_ld = 2'd2;
			2'd2: begin
				n.mark_ld = 2'd0;
				n.mark_time = dout.tstamp;
			end
			default: n.mark_ld = 2'd0;
		endcase
		if (trc && st.wptr == st.mark_idx) begin
			n.mark_time = st.tnow;
		end
		// read data, one wait state
		n.pready = acc;
		n.pslverr = 1'b0;
		n.prdata = 32'h0;
		if (acc) begin
			case (paddr)
				`BTS_CFG: n.prdata = 32'(st.cfg);
				`BTS_OPT: n.prdata = {3'h0, st.opt[3], 3'h0, st.opt[2],
					3'h0, st.opt[1], 3'h0, st.opt[0]};
				`BTS_STAT: n.prdata = 32'({st.cnt, st.wrapped, st.pt_on, st.rt_on,
					st.run, st.seq});
				`BTS_ISTAT: n.prdata = {28'h0, st.irq_st};
				`BTS_IMASK: n.prdata = {28'h0, st.irq_mask};
				`BTS_CMPA: n.prdata = {16'h0, st.cmp_a};
				`BTS_CMPB: n.prdata = {16'h0, st.cmp_b};
				`BTS_CMPD: n.prdata = {16'h0, st.cmp_d};
				`BTS_JUMP: n.prdata = {24'h0, st.jtgt};
				`BTS_MARK: n.prdata = 32'(st.mark_idx);
				`BTS_RDIDX: n.prdata = 32'(st.rd_idx);
				`BTS_TS: n.prdata = ts_view;
				`BTS_SAD: n.prdata = {dout.addr, dout.data};
				`BTS_SINFO: n.prdata = 32'({st.rd_idx, dout.ext, dout.cyc});
				`BTS_RTIME: n.prdata = st.rtime;
				`BTS_PTIME: n.prdata = st.ptime;
				default: n.pslverr = 1'b1;
			endcase
		end
		// register writes at the completing edge
		if (wr) begin
			case (paddr)
				`BTS_CFG: begin
					n.cfg = pwdata[16:0];
					if (!pwdata[0]) begin
						n.run = bts_pkg::BTS_IDLE;
					end else if (st.run == bts_pkg::BTS_IDLE) begin
						n.run = bts_pkg::BTS_RUN;
						n.tnow = 32'h0;
						n.tlast = 32'h0;
						n.seq = 2'd0;
						n.wptr = '0;
						n.cnt = '0;
						n.wrapped = 1'b0;
						n.mark_idx = '0;
						n.rt_on = 1'b0;
						n.pt_on = 1'b0;
						n.rtime = 32'h0;
						n.ptime = 32'h0;
					end
				end
				`BTS_OPT: begin
					for (int i = 0; i < 4; i++) begin
						n.opt[i] = pwdata[8*i +: 5];
					end
				end
				`BTS_ISTAT: clr = pwdata[3:0];
				`BTS_IMASK: n.irq_mask = pwdata[3:0];
				`BTS_CMPA: n.cmp_a = pwdata[15:0];
				`BTS_CMPB: n.cmp_b = pwdata[15:0];
				`BTS_CMPD: n.cmp_d = pwdata[15:0];
				`BTS_JUMP: n.jtgt = pwdata[7:0];
				`BTS_MARK: begin
					if (mk_ok) begin
						n.mark_idx = pwdata[AW-1:0];
						n.mark_ld = 2'd1;
					end
				end
				`BTS_RDIDX: n.rd_idx = pwdata[AW-1:0];
				default: n.rd_idx = st.rd_idx;
			endcase
		end
		// sticky flags, set wins over clear
		n.irq_st = (st.irq_st & ~clr) | set;
		n.irq = |(n.irq_st & n.irq_mask);
		n.halt = n.run == bts_pkg::BTS_HALT;
	end

	// ---------------------------------------------
	// registers
	// ---------------------------------------------
	// power-up options
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.opt <= `BTS_OPT_RST;
			st.cfg <= `BTS_CFG_RST;
		end else begin
			st <= n;
		end
	end

	assign pready = st.pready;
	assign prdata = st.prdata;
	assign pslverr = st.pslverr;
	assign irq = st.irq;
	assign halt_req = st.halt;

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_off_quiet;
		st.opt[st.seq] == `BTS_OPT_OFF |-> !bp_hit && !trc && !rt_ev && !pt_ev;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("off state raised event");
	property p_data_qual;
		bp_hit && st.opt[st.seq] <= 5'h08 |-> b.data == st.cmp_d;
	endproperty
	a_data_qual: assert property (p_data_qual) else $error("data not compared");
	property p_opt0a;
		st.opt[st.seq] == 5'h0a |-> res.bp == 3'd3 && res.tr == 3'd1 && res.addr_only;
	endproperty
	a_opt0a: assert property (p_opt0a) else $error("option 0a resources wrong");
	property p_eos_bound;
		$stable(st.cfg.eos) && bp_hit && !last |=> st.seq <= st.cfg.eos;
	endproperty
	a_eos_bound: assert property (p_eos_bound) else $error("state past end");
	property p_state3_end;
		bp_hit && st.seq == 2'd3 && !wr |=> st.run == bts_pkg::BTS_HALT ##1 halt_req;
	endproperty
	a_state3_end: assert property (p_state3_end) else $error("state three not final");
	property p_jump;
		bp_hit && !last && res.jmp != 2'd0 && jt <= st.cfg.eos && !wr |=> st.seq == $past(jt);
	endproperty
	a_jump: assert property (p_jump) else $error("jump target missed");
	property p_pt_toggle;
		pt_ev && !wr |=> st.pt_on != $past(st.pt_on);
	endproperty
	a_pt_toggle: assert property (p_pt_toggle) else $error("point timer no toggle");
	property p_time_run;
		st.run == bts_pkg::BTS_RUN && !wr |=> st.tnow == $past(st.tnow) + 32'd1;
	endproperty
	a_time_run: assert property (p_time_run) else $error("time stamp not counting");
	property p_mark_keep;
		wr && paddr == `BTS_MARK && !mk_ok |=> $stable(st.mark_idx) && st.mark_ld == 2'd0;
	endproperty
	a_mark_keep: assert property (p_mark_keep) else $error("bad mark accepted");
	property p_irq_level;
		|(st.irq_st & st.irq_mask) |-> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

	c_halt: cover property (bp_hit && last ##2 halt_req);
	c_wrap: cover property (trc && st.wptr == {AW{1'b1}});
	c_mark: cover property (st.mark_ld == 2'd2);
	c_jump: cover property (bp_hit && !last && res.jmp != 2'd0);
endmodule : bts_sequencer
`default_nettype wire

// File: logic/bts_params.svh
`ifndef BTS_PARAMS_SVH
`define BTS_PARAMS_SVH
// register byte offsets
`define BTS_CFG 8'h00
`define BTS_OPT 8'h04
`define BTS_STAT 8'h08
`define BTS_ISTAT 8'h0c
`define BTS_IMASK 8'h10
`define BTS_CMPA 8'h14
`define BTS_CMPB 8'h18
`define BTS_CMPD 8'h1c
`define BTS_JUMP 8'h20
`define BTS_MARK 8'h24
`define BTS_RDIDX 8'h28
`define BTS_TS 8'h2c
`define BTS_SAD 8'h30
`define BTS_SINFO 8'h34
`define BTS_RTIME 8'h38
`define BTS_PTIME 8'h3c
// reset values
`define BTS_CFG_RST 17'h00000
`define BTS_OPT_RST 20'h00002
// interrupt status bits
`define BTS_IRQ_BP 0
`define BTS_IRQ_TRC 1
`define BTS_IRQ_WRAP 2
`define BTS_IRQ_TMR 3
// option code that switches a state off
`define BTS_OPT_OFF 5'h00
// trace view codes
`define BTS_VIEW_DELTA 2'h2
`define BTS_VIEW_MARK 2'h3
// range timer match modes
`define BTS_RM_ONE 2'h0
`define BTS_RM_EITHER 2'h1
`define BTS_RM_IN 2'h2
`endif

// File: logic/bts_pkg.sv
`default_nettype none
package bts_pkg;
	typedef enum logic [1:0] {BTS_IDLE = 2'b00, BTS_RUN = 2'b01, BTS_HALT = 2'b11} bts_run_t;
	typedef struct packed {
		logic [2:0] bp;
		logic [2:0] tr;
		logic [1:0] jmp;
		logic [1:0] rt;
		logic [1:0] pt;
		logic addr_only;
	} bts_res_t;
	typedef struct packed {
		logic valid;
		logic fetch;
		logic [1:0] cyc;
		logic [3:0] ext;
		logic [15:0] addr;
		logic [15:0] data;
	} bts_bus_t;
	typedef struct packed {
		logic [3:0] ext_val;
		logic [3:0] ext_mask;
		logic [1:0] rmode;
		logic [1:0] view;
		logic ext_en;
		logic instruction_fetch_trace_en;
		logic [1:0] eos;
		logic run;
	} bts_cfg_t;
	typedef struct packed {
		logic [31:0] tstamp;
		logic [31:0] delta;
		logic [1:0] cyc;
		logic [3:0] ext;
		logic [15:0] addr;
		logic [15:0] data;
	} bts_smp_t;
endpackage : bts_pkg
`default_nettype wire

// File: logic/bts_option_decode.sv
`default_nettype none
module bts_option_decode (
	// option code in
	input wire logic [4:0] code,
	// resources out
	output bts_pkg::bts_res_t res
);
	// ---------------------------------------------
	// resource table: bp, trace, jump, range, point, address-only
	// ---------------------------------------------
	always_comb begin
		case (code)
			5'h01: res = {3'd2, 3'd0, 2'd0, 2'd0, 2'd0, 1'b0};
			5'h02: res = {3'd1, 3'd1, 2'd0, 2'd0, 2'd0, 1'b0};
			5'h03: res = {3'd1, 3'd1, 2'd0, 2'd0, 2'd0, 1'b0};
			5'h04: res = {3'd1, 3'd1, 2'd0, 2'd0, 2'd0, 1'b0};
			5'h05: res = {3'd2, 3'd0, 2'd0, 2'd0, 2'd0, 1'b0};
			5'h06: res = {3'd1, 3'd1, 2'd0, 2'd0, 2'd0, 1'b0};
			5'h07: res = {3'd1, 3'd1, 2'd0, 2'd0, 2'd0, 1'b0};
			5'h08: res = {3'd2, 3'd0, 2'd0, 2'd0, 2'd0, 1'b0};
			5'h09: res = {3'd4, 3'd0, 2'd0, 2'd0, 2'd0, 1'b1};
			5'h0a: res = {3'd3, 3'd1, 2'd0, 2'd0, 2'd0, 1'b1};
			5'h0b: res = {3'd3, 3'd0, 2'd1, 2'd0, 2'd0, 1'b1};
			5'h0c: res = {3'd3, 3'd0, 2'd0, 2'd0, 2'd1, 1'b1};
			5'h0d: res = {3'd2, 3'd2, 2'd0, 2'd0, 2'd1, 1'b1};
			5'h0e: res = {3'd2, 3'd0, 2'd2, 2'd0, 2'd0, 1'b1};
			5'h0f: res = {3'd2, 3'd0, 2'd0, 2'd1, 2'd0, 1'b1};
			5'h10: res = {3'd2, 3'd0, 2'd0, 2'd0, 2'd2, 1'b1};
			5'h11: res = {3'd2, 3'd1, 2'd1, 2'd0, 2'd0, 1'b1};
			5'h12: res = {3'd2, 3'd1, 2'd0, 2'd0, 2'd1, 1'b1};
			5'h13: res = {3'd2, 3'd0, 2'd1, 2'd0, 2'd1, 1'b1};
			5'h14: res = {3'd1, 3'd3, 2'd0, 2'd0, 2'd0, 1'b1};
			5'h15: res = {3'd1, 3'd2, 2'd1, 2'd0, 2'd0, 1'b1};
			5'h16: res = {3'd1, 3'd2, 2'd0, 2'd0, 2'd1, 1'b1};
			5'h17: res = {3'd1, 3'd1, 2'd2, 2'd0, 2'd0, 1'b1};
			5'h18: res = {3'd1, 3'd1, 2'd0, 2'd1, 2'd0, 1'b1};
			5'h19: res = {3'd1, 3'd0, 2'd2, 2'd0, 2'd1, 1'b1};
			5'h1a: res = {3'd1, 3'd0, 2'd1, 2'd1, 2'd0, 1'b1};
			5'h1b: res = {3'd1, 3'd0, 2'd1, 2'd0, 2'd2, 1'b1};
			5'h1c: res = {3'd1, 3'd0, 2'd0, 2'd1, 2'd1, 1'b1};
			5'h1d: res = {3'd0, 3'd4, 2'd0, 2'd0, 2'd0, 1'b1};
			5'h1e: res = {3'd0, 3'd2, 2'd0, 2'd1, 2'd0, 1'b1};
			5'h1f: res = {3'd0, 3'd1, 2'd0, 2'd2, 2'd1, 1'b1};
			default: res = '0; // code zero: state switched off
		endcase
	end
endmodule : bts_option_decode
`default_nettype wire

// File: logic/bts_trace_mem.sv
`default_nettype none
module bts_trace_mem #(
	parameter int W = 102,
	parameter int AW = 8
) (
	// clock
	input wire logic pclk,
	// write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	// read port, data one cycle after address
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [2**AW];

	// synchronous write and registered read
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : bts_trace_mem
`default_nettype wire

// File: tb/bts_core_model.sv
`default_nettype none
// ------------------------------------------------------------
// monitored core bus: one cycle per call, lines scrambled at rest
// ------------------------------------------------------------
module bts_core_model (
	// clock
	input wire logic pclk,
	// monitored bus pins
	output logic mon_valid,
	output logic mon_fetch,
	output logic [1:0] mon_cyc,
	output logic [3:0] mon_ext,
	output logic [15:0] mon_addr,
	output logic [15:0] mon_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// quiet bus at time zero
	initial begin
		{mon_valid, mon_fetch, mon_cyc, mon_ext, mon_addr, mon_data} = '0;
	end
	// one valid cycle, then gap+1 idle cycles with inverted lines so nothing stale matches
	task automatic cyc(input logic f, input logic [3:0] e, input logic [15:0] a, d, input int gap);
		mon_valid <= 1'b1;
		mon_fetch <= f;
		mon_cyc <= a[1:0];
		mon_ext <= e;
		mon_addr <= a;
		mon_data <= d;
		@(posedge pclk);
		mon_valid <= 1'b0;
		mon_fetch <= ~f;
		mon_ext <= ~e;
		mon_addr <= ~a;
		mon_data <= ~d;
		repeat (gap + 1) @(posedge pclk);
	endtask : cyc
endmodule : bts_core_model
`default_nettype wire

// File: tb/testbench.sv
`include "bts_params.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int AW = 4;
	// qualification cases: option, config, {halt, fetch, ext ok, data ok}
	localparam logic [4:0] QOPT [8] = '{5'h02, 5'h02, 5'h0a, 5'h0a, 5'h0a, 5'h0a, 5'h0a, 5'h00};
	localparam logic [31:0] QCFG [8] = '{1, 1, 1, 9, 9, 32'hbe11, 32'hbe11, 1};
	localparam logic [3:0] QB [8] = '{0, 9, 8, 1, 13, 11, 1, 1};
	// jump cases: target, end state, which is also the state reached
	localparam logic [1:0] JT [3] = '{2, 2, 3};
	localparam logic [1:0] JE [3] = '{2, 1, 3};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, halt_req, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic mon_valid, mon_fetch;
	logic [1:0] mon_cyc;
	logic [3:0] mon_ext;
	logic [15:0] mon_addr, mon_data, cmpd;
	logic [15:0] dat [3];
	int gap [3];
	int fails, check_count;
	bts_sequencer #(.AW(AW)) bts_sequencer_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pready, .prdata, .pslverr, .mon_valid, .mon_fetch, .mon_cyc,
		.mon_ext, .mon_addr, .mon_data, .irq, .halt_req);
	bts_core_model bts_core_model_i (.pclk, .mon_valid, .mon_fetch, .mon_cyc, .mon_ext,
		.mon_addr, .mon_data);
	// 40 MHz clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// compare and count
	task automatic chk(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// apb transfer: setup, access until pready, then one idle cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge pclk);
		end
		if (n == 50) fails++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, '0);
		chk(q, exp);
	endtask : rd
	// one core cycle at address a, then time for the event to land
	task automatic hit(input logic f, input logic [3:0] x, input logic [15:0] a, d);
		bts_core_model_i.cyc(f, x, a, d, 0);
		repeat (4) @(posedge pclk);
	endtask : hit
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	// watchdog
	initial begin
		#500000;
		fails++;
		final_report();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		fails = 0;
		check_count = 0;
		void'($urandom(25227));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`BTS_CFG, 32'h0);
		rd(`BTS_OPT, 32'h2);
		rd(`BTS_STAT, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk({e, q}, {1'b1, 32'h0});
		wr(`BTS_OPT, $urandom);
		rd(`BTS_OPT, pwdata & 32'h1f1f1f1f);
		wr(`BTS_STAT, '1);
		rd(`BTS_STAT, 32'h0);
		$display("test registers done");
		wr(`BTS_OPT, 32'h0a);
		wr(`BTS_CMPA, 32'h0100);
		wr(`BTS_CMPB, 32'h01ff);
		wr(`BTS_IMASK, 32'h1);
		// end state on the armed state
		wr(`BTS_CFG, 32'h41);
		foreach (gap[k]) begin
			gap[k] = $urandom_range(6);
			dat[k] = 16'($urandom);
			bts_core_model_i.cyc(1'b0, 4'h0, 16'h0150 + 16'(k), dat[k], gap[k]);
		end
		repeat (4) @(posedge pclk);
		rd(`BTS_STAT, 32'h184);
		for (int k = 1; k < 3; k++) begin
			wr(`BTS_RDIDX, 32'(k));
			rd(`BTS_TS, 32'(gap[k - 1] + 2));
			rd(`BTS_SAD, {16'h0150 + 16'(k), dat[k]});
		end
		wr(`BTS_CFG, 32'h61);
		rd(`BTS_TS, 32'(gap[0] + gap[1] + 4));
		wr(`BTS_MARK, 32'h1);
		rd(`BTS_TS, 32'(gap[1] + 2));
		wr(`BTS_MARK, 32'h7);
		rd(`BTS_TS, 32'(gap[1] + 2));
		wr(`BTS_RDIDX, 32'h0);
		rd(`BTS_TS, 32'(-(gap[0] + 2)));
		hit(1'b0, 4'h0, 16'h0100, 16'($urandom));
		chk({halt_req, irq}, 2'b11);
		wr(`BTS_ISTAT, 32'h1);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		wr(`BTS_CFG, 32'h0);
		@(posedge pclk);
		chk({31'h0, halt_req}, 32'h0);
		$display("test trace views done");
		cmpd = 16'($urandom);
		wr(`BTS_CMPD, {16'h0, cmpd});
		for (int k = 0; k < 8; k++) begin
			wr(`BTS_OPT, {27'h0, QOPT[k]});
			wr(`BTS_CFG, QCFG[k]);
			hit(QB[k][2], QB[k][1] ? 4'h5 : 4'h4, 16'h0100, QB[k][0] ? cmpd : ~cmpd);
			chk({31'h0, halt_req}, {31'h0, QB[k][3]});
			wr(`BTS_CFG, 32'h0);
		end
		$display("test qualification done");
		wr(`BTS_OPT, 32'h0a0a0a0b);
		for (int k = 0; k < 3; k++) begin
			wr(`BTS_JUMP, {30'h0, JT[k]});
			// end state on an armed state
			wr(`BTS_CFG, {29'h0, JE[k], 1'b1});
			hit(1'b0, 4'h0, 16'h0100, 16'($urandom));
			apb(1'b0, `BTS_STAT, 32'h0);
			chk({29'h0, halt_req, q[1:0]}, {30'h0, JE[k]});
			hit(1'b0, 4'h0, 16'h0100, 16'($urandom));
			chk({31'h0, halt_req}, 32'h1);
			wr(`BTS_CFG, 32'h0);
		end
		$display("test jumps done");
		// range timer in inside-range mode, then point timer on the second compare
		for (int k = 0; k < 2; k++) begin
			wr(`BTS_OPT, k ? 32'h1b : 32'h0f);
			wr(`BTS_CFG, 32'h101);
			bts_core_model_i.cyc(1'b0, 4'h0, k ? 16'h01ff : 16'h0150, 16'h0, gap[k]);
			hit(1'b0, 4'h0, k ? 16'h01ff : 16'h0160, 16'h0);
			rd(k ? `BTS_PTIME : `BTS_RTIME, 32'(gap[k] + 2));
			wr(`BTS_CFG, 32'h0);
		end
		$display("test timers done");
		final_report();
	end
endmodule : testbench
`default_nettype wire
